// file: rtl/write_buffer_pkg.sv
`default_nettype none
package write_buffer_pkg;
    // shared-memory header, host byte offsets of 16-bit words
    localparam logic [11:0] COUNT_OFFSET    = 12'h7E6;
    localparam logic [11:0] BASE_OFFSET     = 12'h7E8;
    // device address that maps to shared word 0
    localparam logic [15:0] WINDOW_DEV_BASE = 16'hD000;
    localparam int          MAX_ENTRIES     = 32;
    localparam int          ENTRY_WORDS     = 6;
    localparam int          REG_BITS        = 24;
    localparam int          LONG_BITS       = 48;
    // code word field positions
    localparam int          TYPE_LSB        = 0;
    localparam int          TYPE_BITS       = 3;
    localparam int          WIDTH_LSB       = 3;
    localparam int          WIDTH_BITS      = 5;
    localparam int          OFFS_LSB        = 8;
    localparam int          OFFS_BITS       = 5;
    localparam int          SPEC_LSB        = 13;
    localparam int          SPEC_BITS       = 3;
    localparam logic [4:0]  OFFS_MAX        = 5'h17;
    localparam logic [2:0]  SPEC_FUNC_BLOCK = 3'h0;
    // target type codes
    localparam logic [2:0]  TYPE_UPPER      = 3'h0;
    localparam logic [2:0]  TYPE_LONG       = 3'h1;
    localparam logic [2:0]  TYPE_LOWER      = 3'h2;
    localparam logic [2:0]  TYPE_SPEC_UPPER = 3'h4;
    localparam logic [2:0]  TYPE_SPEC_LOWER = 3'h6;
    // shared-memory read latency in cycles
    localparam int          READ_LATENCY    = 1;
endpackage
`default_nettype wire

// file: rtl/write_field_decode.sv
`default_nettype none
module write_field_decode (
    input  wire logic [15:0] code,
    input  wire logic [31:0] data1,
    input  wire logic [31:0] data2,
    output logic             legal,
    output logic [47:0]      wdata,
    output logic [47:0]      wmask
);
    function automatic logic width_ok(input logic [4:0] w);
        return (w == 5'h00) || (w == 5'h01) || (w == 5'h04) || (w == 5'h08) ||
               (w == 5'h0C) || (w == 5'h10) || (w == 5'h14);
    endfunction

    wire logic [2:0]  type_f  = code[write_buffer_pkg::TYPE_LSB  +: write_buffer_pkg::TYPE_BITS];
    wire logic [4:0]  width_f = code[write_buffer_pkg::WIDTH_LSB +: write_buffer_pkg::WIDTH_BITS];
    wire logic [4:0]  offs_f  = code[write_buffer_pkg::OFFS_LSB  +: write_buffer_pkg::OFFS_BITS];
    wire logic [2:0]  spec_f  = code[write_buffer_pkg::SPEC_LSB  +: write_buffer_pkg::SPEC_BITS];
    wire logic        type_ok = (type_f == write_buffer_pkg::TYPE_UPPER) ||
                                (type_f == write_buffer_pkg::TYPE_LONG) ||
                                (type_f == write_buffer_pkg::TYPE_LOWER) ||
                                (type_f == write_buffer_pkg::TYPE_SPEC_UPPER) ||
                                (type_f == write_buffer_pkg::TYPE_SPEC_LOWER);
    wire logic [5:0]  nbits   = (width_f == 5'h00) ? 6'(write_buffer_pkg::REG_BITS) : {1'b0, width_f};
    wire logic [47:0] ones    = (48'h0000_0000_0001 << nbits) - 48'h0000_0000_0001;
    // field placed at offset, clipped to the register
    wire logic [47:0] pmask   = (ones << offs_f) & 48'h0000_00FF_FFFF;
    wire logic        is_long = (type_f == write_buffer_pkg::TYPE_LONG);

    assign legal = type_ok && width_ok(width_f) && (offs_f <= write_buffer_pkg::OFFS_MAX) &&
                   (spec_f == write_buffer_pkg::SPEC_FUNC_BLOCK);
    // long target takes data1 then low half of data2
    assign wdata = is_long ? {data2[15:0], data1} : (({24'h00_0000, data1[23:0]} << offs_f) & pmask);
    // mask marks the bits of the target that are written
    assign wmask = is_long ? 48'hFFFF_FFFF_FFFF : pmask;
endmodule
`default_nettype wire

// file: rtl/entry_word_gather.sv
`default_nettype none
module entry_word_gather (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clear,
    input  wire logic        push,
    input  wire logic [15:0] word,
    output logic             full,
    output logic [15:0]      target,
    output logic [15:0]      code,
    output logic [31:0]      data1,
    output logic [31:0]      data2
);
    logic [15:0] entry_q [write_buffer_pkg::ENTRY_WORDS];
    logic [2:0]  idx_r;

    always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
            idx_r <= 3'h0;
        end else if (push) begin
            entry_q[idx_r] <= word;
            idx_r          <= idx_r + 3'h1;
        end
    end

    assign full   = (idx_r == 3'(write_buffer_pkg::ENTRY_WORDS));
    assign target = entry_q[0];
    assign code   = entry_q[1];
    // each row is low half then high half
    assign data1  = {entry_q[3], entry_q[2]};
    assign data2  = {entry_q[5], entry_q[4]};
endmodule
`default_nettype wire

// file: rtl/host_variable_write_buffer.sv
// Overview of operation
// - table holds at most thirty-two entries, each one target register or field.
// - entries are six 16-bit words each, packed from the header base.
// - count word holds 1 to 32; nonzero means table ready.
// - no target write happens while count reads zero.
// - nonzero count copies exactly that many entries from the base; counts above 32 copy 32.
// - count word cleared to zero when all entries are done.
// - engine starts a pass only while the enable setting is one.
// - code bits 0-2 select upper, long, lower, special upper, special lower.
// - code bits 13-15 must be zero, function block; others reserved.
// - short and special targets take first data word, ignore second.
// - long target takes data1 as low 32, data2 low 16 as top.
// - each 32-bit datum is low half then high half in a row.
`default_nettype none
module host_variable_write_buffer #(
    parameter int READ_LATENCY = write_buffer_pkg::READ_LATENCY,
    parameter int MAX_ENTRIES  = write_buffer_pkg::MAX_ENTRIES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        variable_buffer_enable,
    input  wire logic        bg_tick,
    output logic [11:0]      dp_addr,
    output logic             dp_rd,
    output logic             dp_wr,
    output logic [15:0]      dp_wdata,
    input  wire logic [15:0] dp_rdata,
    output logic             reg_wr,
    output logic [2:0]       reg_space,
    output logic [15:0]      reg_addr,
    output logic [47:0]      reg_wdata,
    output logic [47:0]      reg_wmask,
    output logic             entry_rejected,
    output logic             busy,
    output logic             cycle_done
);
    if (READ_LATENCY < 1 || READ_LATENCY > 8) begin : g_bad_latency
        $error("READ_LATENCY must be 1 to 8");
    end
    if (MAX_ENTRIES < 1 || MAX_ENTRIES > 63) begin : g_bad_entries
        $error("MAX_ENTRIES must be 1 to 63");
    end

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0000,
        ST_CNT_RD  = 4'b0001,
        ST_CNT_WT  = 4'b0010,
        ST_BASE_RD = 4'b0011,
        ST_BASE_WT = 4'b0100,
        ST_ENT_RD  = 4'b0101,
        ST_ENT_WT  = 4'b0110,
        ST_APPLY   = 4'b0111,
        ST_CLEAR   = 4'b1000
    } state_e;

    localparam logic [11:0] COUNT_WORD = write_buffer_pkg::COUNT_OFFSET >> 1;
    localparam logic [11:0] BASE_WORD  = write_buffer_pkg::BASE_OFFSET >> 1;
    localparam logic [5:0]  ENT_LIMIT  = 6'(MAX_ENTRIES);

    state_e                   st_r, st_nxt;
    logic [11:0]              addr_r, addr_nxt;
    logic [5:0]               total_r, total_nxt;
    logic [5:0]               done_r;
    logic [READ_LATENCY-1:0]  rd_pipe_r;
    logic [11:0]              dp_addr_r;
    logic                     dp_rd_r, dp_wr_r;
    logic                     reg_wr_r, rej_r, busy_r, cdone_r;
    logic [2:0]               space_r;
    logic [15:0]              raddr_r;
    logic [47:0]              wdata_r, wmask_r;

    wire logic        rvalid = rd_pipe_r[READ_LATENCY-1];
    wire logic        ent_full;
    wire logic        dec_legal;
    wire logic [15:0] ent_target, ent_code;
    wire logic [31:0] ent_d1, ent_d2;
    wire logic [47:0] dec_wdata, dec_wmask;
    // base arrives as a device address, two words per location
    wire logic [15:0] base_rel   = dp_rdata - write_buffer_pkg::WINDOW_DEV_BASE;
    wire logic [11:0] base_word  = {base_rel[10:0], 1'b0};
    // counts above the table size are clamped
    wire logic [5:0]  cnt_clamp  = (dp_rdata > 16'(MAX_ENTRIES)) ? ENT_LIMIT : dp_rdata[5:0];
    wire logic        last_entry = (done_r + 6'h01) == total_r;
    wire logic        start      = (st_r == ST_IDLE) && bg_tick && variable_buffer_enable;

    entry_word_gather u_gather (
        .clk    (clk),
        .rst_n  (rst_n),
        .clear  (st_r == ST_APPLY),
        .push   ((st_r == ST_ENT_WT) && rvalid),
        .word   (dp_rdata),
        .full   (ent_full),
        .target (ent_target),
        .code   (ent_code),
        .data1  (ent_d1),
        .data2  (ent_d2)
    );

    write_field_decode u_decode (
        .code  (ent_code),
        .data1 (ent_d1),
        .data2 (ent_d2),
        .legal (dec_legal),
        .wdata (dec_wdata),
        .wmask (dec_wmask)
    );

    always_comb begin
        st_nxt    = st_r;
        addr_nxt  = addr_r;
        total_nxt = total_r;
        case (st_r)
            // only a tick with the enable set starts a pass
            ST_IDLE:    if (start) st_nxt = ST_CNT_RD;
            ST_CNT_RD:  st_nxt = ST_CNT_WT;
            ST_CNT_WT: begin
                if (rvalid) begin
                    // zero count means host still preparing
                    // host owns the table until count is nonzero
                    st_nxt    = (dp_rdata == 16'h0000) ? ST_IDLE : ST_BASE_RD;
                    total_nxt = cnt_clamp;
                end
            end
            ST_BASE_RD: st_nxt = ST_BASE_WT;
            ST_BASE_WT: begin
                if (rvalid) begin
                    st_nxt   = ST_ENT_RD;
                    addr_nxt = base_word;
                end
            end
            // full entry seen here, after its sixth word has landed
            ST_ENT_RD:  st_nxt = ent_full ? ST_APPLY : ST_ENT_WT;
            ST_ENT_WT: begin
                if (rvalid) begin
                    addr_nxt = addr_r + 12'h001;
                    st_nxt   = ST_ENT_RD;
                end
            end
            ST_APPLY: begin
                // stop after exactly the clamped count
                st_nxt = last_entry ? ST_CLEAR : ST_ENT_RD;
            end
            ST_CLEAR:   st_nxt = ST_IDLE;
            default:    st_nxt = ST_IDLE;
        endcase
    end

    // gather fills on the push of the sixth word; apply waits one cycle for it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r    <= ST_IDLE;
            addr_r  <= 12'h000;
            total_r <= 6'h00;
        end else begin
            st_r    <= st_nxt;
            addr_r  <= addr_nxt;
            total_r <= total_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || st_r == ST_IDLE) begin
            done_r <= 6'h00;
        end else if (st_r == ST_APPLY) begin
            done_r <= done_r + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_pipe_r <= '0;
        end else begin
            rd_pipe_r <= (READ_LATENCY)'({rd_pipe_r, dp_rd_r});
        end
    end

    wire logic        issue_rd = (st_r == ST_CNT_RD) || (st_r == ST_BASE_RD) ||
                                 ((st_r == ST_ENT_RD) && !ent_full);
    wire logic [11:0] rd_addr  = (st_r == ST_CNT_RD)  ? COUNT_WORD :
                                 (st_r == ST_BASE_RD) ? BASE_WORD : addr_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dp_rd_r   <= 1'b0;
            dp_wr_r   <= 1'b0;
            dp_addr_r <= 12'h000;
        end else begin
            dp_rd_r   <= issue_rd;
            // count word cleared once all entries are written or rejected
            dp_wr_r   <= (st_r == ST_CLEAR);
            dp_addr_r <= (st_r == ST_CLEAR) ? COUNT_WORD : rd_addr;
        end
    end

    wire logic apply_now = (st_r == ST_APPLY) && ent_full;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_wr_r <= 1'b0;
            rej_r    <= 1'b0;
            space_r  <= 3'h0;
            raddr_r  <= 16'h0000;
            wdata_r  <= 48'h0000_0000_0000;
            wmask_r  <= 48'h0000_0000_0000;
        end else begin
            // reserved or malformed codes are dropped
            reg_wr_r <= apply_now && dec_legal;
            rej_r    <= apply_now && !dec_legal;
            // rejected entries leave the target fields as they were
            if (apply_now && dec_legal) begin
                space_r <= ent_code[write_buffer_pkg::TYPE_LSB +: write_buffer_pkg::TYPE_BITS];
                raddr_r <= ent_target;
                wdata_r <= dec_wdata;
                wmask_r <= dec_wmask;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_r  <= 1'b0;
            cdone_r <= 1'b0;
        end else begin
            busy_r  <= (st_nxt != ST_IDLE);
            cdone_r <= dp_wr_r;
        end
    end

    assign dp_addr        = dp_addr_r;
    assign dp_rd          = dp_rd_r;
    assign dp_wr          = dp_wr_r;
    assign dp_wdata       = 16'h0000;
    assign reg_wr         = reg_wr_r;
    assign reg_space      = space_r;
    assign reg_addr       = raddr_r;
    assign reg_wdata      = wdata_r;
    assign reg_wmask      = wmask_r;
    assign entry_rejected = rej_r;
    assign busy           = busy_r;
    assign cycle_done     = cdone_r;

    // helper: writes and rejects seen in the current pass
    logic [5:0] seen_r;
    always_ff @(posedge clk) begin
        if (!rst_n || st_r == ST_CNT_RD) begin
            seen_r <= 6'h00;
        end else if (reg_wr_r || rej_r) begin
            seen_r <= seen_r + 6'h01;
        end
    end

    sequence cnt_zero_seen;
        (st_r == ST_CNT_WT) && rvalid && (dp_rdata == 16'h0000);
    endsequence

    AST_ZERO_COUNT_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        cnt_zero_seen |=> (st_r == ST_IDLE) ##0 (!reg_wr_r && !dp_wr_r) [*2])
        else $error("write issued after zero count");

    AST_DISABLED_STAYS: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == ST_IDLE) && !variable_buffer_enable |=> (st_r == ST_IDLE))
        else $error("engine left idle while disabled");

    AST_EXACT_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
        cdone_r |-> (seen_r == total_r))
        else $error("entries handled differ from count");

    AST_CLEAR_WORD: assert property (@(posedge clk) disable iff (!rst_n)
        dp_wr_r |-> (dp_addr_r == COUNT_WORD) && (dp_wdata == 16'h0000) ##1 cdone_r)
        else $error("count clear malformed");

    AST_TABLE_LIMIT: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r != ST_IDLE) && (st_r != ST_CNT_RD) && (st_r != ST_CNT_WT) |->
            (total_r >= 6'h01) && (total_r <= ENT_LIMIT))
        else $error("entry count out of range");

    AST_FIRST_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == ST_BASE_WT) && rvalid |=> ##1 dp_rd_r && (dp_addr_r == $past(base_word, 2)))
        else $error("first entry not fetched at base");

    AST_LONG_FULL: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr_r && (space_r == write_buffer_pkg::TYPE_LONG) |-> (reg_wmask == 48'hFFFF_FFFF_FFFF))
        else $error("long write not full width");

    AST_PARTIAL_MASK: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr_r && (space_r != write_buffer_pkg::TYPE_LONG) |->
            (wmask_r[47:24] == 24'h00_0000) && ((wdata_r & ~wmask_r) == 48'h0000_0000_0000))
        else $error("data outside selected field");

    AST_REJECT_NO_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        rej_r |-> !reg_wr_r && $stable(raddr_r) && $stable(wdata_r))
        else $error("rejected entry wrote target");
endmodule
`default_nettype wire

// file: dv/shared_mem_model.sv
`default_nettype none
module shared_mem_model (
    input  wire logic        clk,
    input  wire logic [11:0] dp_addr,
    input  wire logic        dp_rd,
    input  wire logic        dp_wr,
    input  wire logic [15:0] dp_wdata,
    output logic [15:0]      dp_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] mem [0:4095];

    initial dp_rdata = 16'h0000;

    // off-cycle word inverts so a late sample never sees stale data
    always @(posedge clk) begin
        if (dp_wr) begin
            mem[dp_addr] <= dp_wdata;
        end
        if (dp_rd) begin
            dp_rdata <= mem[dp_addr];
        end else begin
            dp_rdata <= ~dp_rdata;
        end
    end
endmodule
`default_nettype wire

// file: dv/test_host_variable_write_buffer.sv
`default_nettype none
module test_host_variable_write_buffer;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] TBL = 12'h400;
    localparam logic [11:0] CNT_W = 12'h3F3;
    localparam logic [11:0] BASE_W = 12'h3F4;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        variable_buffer_enable = 1'b0;
    logic        bg_tick = 1'b0;
    logic [11:0] dp_addr;
    logic        dp_rd;
    logic        dp_wr;
    logic [15:0] dp_wdata;
    logic [15:0] dp_rdata;
    logic        reg_wr;
    logic [2:0]  reg_space;
    logic [15:0] reg_addr;
    logic [47:0] reg_wdata;
    logic [47:0] reg_wmask;
    logic        entry_rejected;
    logic        busy;
    logic        cycle_done;
    int          n_errors = 0;
    int          compares = 0;
    int          n_wr = 0;
    int          n_rej = 0;
    logic [15:0] q_addr [$];
    logic [2:0]  q_space [$];
    logic [47:0] q_data [$];
    logic [47:0] q_mask [$];
    logic [15:0] e_addr [32];
    logic [15:0] e_code [32];
    logic [31:0] e_d1 [32];
    logic [31:0] e_d2 [32];

    always #2 clk = ~clk;

    host_variable_write_buffer dut (
        .clk(clk), .rst_n(rst_n), .variable_buffer_enable(variable_buffer_enable), .bg_tick(bg_tick),
        .dp_addr(dp_addr), .dp_rd(dp_rd), .dp_wr(dp_wr), .dp_wdata(dp_wdata), .dp_rdata(dp_rdata),
        .reg_wr(reg_wr), .reg_space(reg_space), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wmask(reg_wmask), .entry_rejected(entry_rejected), .busy(busy), .cycle_done(cycle_done)
    );

    shared_mem_model mem_model (
        .clk(clk), .dp_addr(dp_addr), .dp_rd(dp_rd), .dp_wr(dp_wr), .dp_wdata(dp_wdata), .dp_rdata(dp_rdata)
    );

    always @(negedge clk) begin
        if (reg_wr === 1'b1) begin
            n_wr++;
            q_addr.push_back(reg_addr);
            q_space.push_back(reg_space);
            q_data.push_back(reg_wdata);
            q_mask.push_back(reg_wmask);
        end
        if (entry_rejected === 1'b1) begin
            n_rej++;
        end
    end

    task automatic wrap_up();
        if (n_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [15:0] mk(input logic [2:0] s, input logic [4:0] o, input logic [4:0] w,
                                       input logic [2:0] t);
        return {s, o, w, t};
    endfunction

    task automatic put(input int i, input logic [15:0] a, input logic [15:0] c, input logic [31:0] d1,
                       input logic [31:0] d2);
        e_addr[i] = a;
        e_code[i] = c;
        e_d1[i] = d1;
        e_d2[i] = d2;
    endtask

    task automatic run(input int n, input logic [15:0] cnt, input logic exp_done);
        int k;
        @(negedge clk);
        q_addr.delete();
        q_space.delete();
        q_data.delete();
        q_mask.delete();
        n_wr = 0;
        n_rej = 0;
        // target, code, data halves low first, no address zero
        for (int i = 0; i < n; i++) begin
            mem_model.mem[TBL + 12'(6 * i)] = e_addr[i];
            mem_model.mem[TBL + 12'(6 * i + 1)] = e_code[i];
            mem_model.mem[TBL + 12'(6 * i + 2)] = e_d1[i][15:0];
            mem_model.mem[TBL + 12'(6 * i + 3)] = e_d1[i][31:16];
            mem_model.mem[TBL + 12'(6 * i + 4)] = e_d2[i][15:0];
            mem_model.mem[TBL + 12'(6 * i + 5)] = e_d2[i][31:16];
        end
        // base as device address, count written last
        mem_model.mem[BASE_W] = 16'hD200;
        mem_model.mem[CNT_W] = cnt;
        bg_tick = 1'b1;
        @(negedge clk);
        bg_tick = 1'b0;
        check("busy_start", 48'(busy), 48'(variable_buffer_enable));
        k = 0;
        while (cycle_done !== 1'b1 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        repeat (3) @(negedge clk);
        check("cycle_done", 48'(k < 2000), 48'(exp_done));
        check("count_word", 48'(mem_model.mem[CNT_W]), exp_done ? 48'h0 : 48'(cnt));
        check("busy", 48'(busy), 48'h0);
    endtask

    task automatic cmp(input int j, input int i);
        logic [47:0] m;
        logic [47:0] d;
        int          w;
        w = (e_code[i][7:3] == 5'h00) ? 24 : int'(e_code[i][7:3]);
        m = ((48'h1 << w) - 48'h1) << e_code[i][12:8];
        d = ({16'h0000, e_d1[i]} & ((48'h1 << w) - 48'h1)) << e_code[i][12:8];
        if (e_code[i][2:0] == write_buffer_pkg::TYPE_LONG) begin
            m = '1;
            d = {e_d2[i][15:0], e_d1[i]};
        end
        if (j >= q_addr.size()) begin
            check("write_present", 48'h0, 48'h1);
        end else begin
            check("reg_addr", 48'(q_addr[j]), 48'(e_addr[i]));
            check("reg_space", 48'(q_space[j]), 48'(e_code[i][2:0]));
            check("reg_wdata", q_data[j], d);
            check("reg_wmask", q_mask[j], m);
        end
    endtask

    task automatic t_quiet();
        put(0, 16'h0011, mk(3'h0, 5'h00, 5'h00, write_buffer_pkg::TYPE_UPPER), 32'h00123456, 32'h0);
        run(1, 16'h0000, 1'b0);
        check("writes_zero_count", 48'(n_wr), 48'h0);
        variable_buffer_enable = 1'b0;
        run(1, 16'h0001, 1'b0);
        check("writes_disabled", 48'(n_wr), 48'h0);
        variable_buffer_enable = 1'b1;
    endtask

    task automatic t_kinds();
        logic [2:0] t [5];
        t = '{write_buffer_pkg::TYPE_UPPER, write_buffer_pkg::TYPE_LONG, write_buffer_pkg::TYPE_LOWER,
              write_buffer_pkg::TYPE_SPEC_UPPER, write_buffer_pkg::TYPE_SPEC_LOWER};
        // special types used for function blocks
        for (int i = 0; i < 5; i++) begin
            put(i, 16'h0100 + 16'(i), mk(3'h0, 5'h00, 5'h00, t[i]), 32'hA5C3_9E71 + 32'(i), 32'h5A5A_BEEF);
        end
        put(5, 16'h0777, mk(3'h0, 5'h00, 5'h00, write_buffer_pkg::TYPE_UPPER), 32'h1, 32'h0);
        run(6, 16'h0005, 1'b1);
        check("writes_kinds", 48'(n_wr), 48'h5);
        for (int i = 0; i < 5; i++) begin
            cmp(i, i);
        end
    endtask

    task automatic t_fields();
        int w [6];
        w = '{1, 4, 8, 12, 16, 20};
        for (int i = 0; i < 6; i++) begin
            put(i, 16'h0200 + 16'(i), mk(3'h0, 5'(24 - w[i]), 5'(w[i]), write_buffer_pkg::TYPE_LOWER),
                32'hFFF3_6C9D, 32'h0F0F_0F0F);
        end
        run(6, 16'h0006, 1'b1);
        check("writes_fields", 48'(n_wr), 48'h6);
        for (int i = 0; i < 6; i++) begin
            cmp(i, i);
        end
    endtask

    task automatic t_reject();
        put(0, 16'h0300, mk(3'h0, 5'h00, 5'h00, 3'h3), 32'h1, 32'h0);
        put(1, 16'h0301, mk(3'h0, 5'h00, 5'h00, 3'h5), 32'h1, 32'h0);
        put(2, 16'h0302, mk(3'h0, 5'h00, 5'h00, 3'h7), 32'h1, 32'h0);
        put(3, 16'h0303, mk(3'h0, 5'h00, 5'h02, 3'h0), 32'h1, 32'h0);
        put(4, 16'h0304, mk(3'h0, 5'h18, 5'h01, 3'h0), 32'h1, 32'h0);
        put(5, 16'h0305, mk(3'h1, 5'h00, 5'h00, 3'h4), 32'h1, 32'h0);
        put(6, 16'h0306, mk(3'h0, 5'h04, 5'h08, 3'h2), 32'h0000_00C7, 32'h0);
        run(7, 16'h0007, 1'b1);
        check("rejects", 48'(n_rej), 48'h6);
        check("writes_reject", 48'(n_wr), 48'h1);
        cmp(0, 6);
    endtask

    task automatic t_full();
        for (int i = 0; i < 32; i++) begin
            put(i, 16'h0400 + 16'(i), mk(3'h0, 5'(i % 16), 5'h08, write_buffer_pkg::TYPE_UPPER),
                32'h0000_0081 + 32'(i * 3), 32'h0);
        end
        run(32, 16'h0020, 1'b1);
        check("writes_full", 48'(n_wr), 48'h20);
        for (int i = 0; i < 32; i++) begin
            cmp(i, i);
        end
        // oversized count is held to the table size
        run(32, 16'h0021, 1'b1);
        check("writes_clamped", 48'(n_wr), 48'h20);
    endtask

    // run ends well under the limit; a hang counts as a mismatch
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        wrap_up();
    end

    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        variable_buffer_enable = 1'b1;
        t_quiet();
        t_kinds();
        t_fields();
        t_reject();
        t_full();
        wrap_up();
    end
endmodule
`default_nettype wire
